// ### common/adcsw_pkg.sv
// Purpose: Shared constants and types for the converter control block.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes:   Offsets are byte addresses.
package adcsw_pkg;
  // ============================================================
  // Register map
  localparam logic [7:0]  ADDR_STATUS   = 8'h00;
  localparam logic [7:0]  ADDR_CTRL0    = 8'h04;
  localparam logic [7:0]  ADDR_THRESH   = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h10;
  localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;
  localparam logic [31:0] CTRL0_WMASK   = 32'h008F_EB7F;
  localparam logic [31:0] THRESH_RESET  = 32'h0FFF_0000;
  // ============================================================
  // Field positions of conversion_control_0
  localparam int WDOG_EN_BIT   = 23;
  localparam int SYNC_LSB      = 16;
  localparam int BURST_LSB     = 13;
  localparam int BURST_EN_BIT  = 11;
  localparam int WDOG_SC_BIT   = 9;
  localparam int SCAN_BIT      = 8;
  localparam int WDOG_IE_BIT   = 6;
  localparam int DONE_IE_BIT   = 5;
  localparam int WDOG_CH_LSB   = 0;
  // Status bit positions.
  localparam int STAT_WDOG_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam logic [4:0] MAX_CHANNEL = 5'h11;
  // ============================================================
  // Follow-up delays in converter clock cycles
  localparam logic [4:0] FAST_DELAY = 5'h07;
  localparam logic [4:0] SLOW_DELAY = 5'h0E;
  // ============================================================
  // Types
  typedef enum logic [3:0] {
    SYNC_FREE     = 4'h0,
    SYNC_PARALLEL = 4'h6,
    SYNC_FU_FAST  = 4'h7,
    SYNC_FU_SLOW  = 4'h8
  } adcsw_sync_t;
  typedef struct packed {
    logic       watchdog_enable;
    logic [3:0] sync_select;
    logic [2:0] burst_count;
    logic       burst_enable;
    logic       single_channel;
    logic       scan_enable;
    logic       wdog_irq_enable;
    logic       done_irq_enable;
    logic [4:0] channel_select;
  } adcsw_ctrl_t;
  typedef struct packed {
    logic        valid;
    logic [4:0]  channel;
    logic [11:0] value;
    logic        seq_last;
  } adcsw_result_t;
endpackage : adcsw_pkg

// ### rtl/adcsw_ctrl.sv
// Purpose: Sequencing, watchdog and sync control register of a converter.
// Assumes: One clock; AXI4-Lite slave; engine reports results on a port.
// Notes:   Behaviour
// Behaviour
// - Control word sits at offset 0x04 and reads zero after reset.
// - Bit 23 enables the watchdog on routine conversion results.
// - Bits 19:16 select free, parallel, fast or slow follow-up modes.
// - Sync field acts only in the primary converter's instance.
// - Discontinuous bursts convert burst count plus one channels.
// - Bit 11 splits the routine sequence into triggered bursts.
// - Bit 9 restricts the watchdog to the selected channel when scanning.
// - Bit 8 enables stepping through the routine sequence.
// - Bit 6 gates the watchdog flag onto the interrupt.
// - Bit 5 gates the end of conversion flag onto the interrupt.
// - Bits 4:0 pick channel 0 to 17 for single-channel watchdog.
// - Finishing a routine sequence sets the end of conversion flag.
// - A value outside the thresholds sets the watchdog event flag.
// - Fast follow-up starts secondary now, primary seven cycles later.
// - Slow follow-up: secondary, primary after 14, secondary after 14.
`timescale 1ns/1ps
module adcsw_ctrl
  import adcsw_pkg::*;
#(
  parameter bit IS_PRIMARY = 1'b1
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Conversion engine
  input  wire adcsw_result_t result,
  input  wire logic        trigger,
  output adcsw_ctrl_t      ctrl,
  output logic [3:0]       burst_length,
  output logic             start_primary,
  output logic             start_secondary,
  // Interrupt
  output logic             irq
);
  // ============================================================
  // Register state
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] thresh_reg, thresh_next;
  logic [1:0]  stat_reg, stat_next;
  logic [1:0]  mask_reg, mask_next;
  logic        aw_reg, aw_next, w_reg, w_next, b_reg, b_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        r_reg, r_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] wmerge;
  logic        wr_fire, out_of_range, wdog_hit, done_hit;
  adcsw_sync_t sync_mode;

  typedef enum {ST_IDLE, ST_WAIT_PRI, ST_WAIT_SEC} adcsw_seq_t;
  adcsw_seq_t  seq_reg, seq_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic        pri_reg, pri_next, sec_reg, sec_next;

  // ============================================================
  // Field decode
  always_comb begin
    ctrl.watchdog_enable = ctrl_reg[WDOG_EN_BIT];
    ctrl.sync_select     = ctrl_reg[SYNC_LSB +: 4];
    ctrl.burst_count     = ctrl_reg[BURST_LSB +: 3];
    ctrl.burst_enable    = ctrl_reg[BURST_EN_BIT];
    ctrl.single_channel  = ctrl_reg[WDOG_SC_BIT];
    ctrl.scan_enable     = ctrl_reg[SCAN_BIT];
    ctrl.wdog_irq_enable = ctrl_reg[WDOG_IE_BIT];
    ctrl.done_irq_enable = ctrl_reg[DONE_IE_BIT];
    ctrl.channel_select  = ctrl_reg[WDOG_CH_LSB +: 5];
  end
  // A zero burst count still converts one channel.
  assign burst_length = ctrl.burst_enable ? {1'b0, ctrl.burst_count} + 4'h1
                                          : 4'h0;
  // The secondary converter ignores its own copy of the sync field.
  assign sync_mode = IS_PRIMARY ? adcsw_sync_t'(ctrl.sync_select)
                                : SYNC_FREE;

  // ============================================================
  // Watchdog and status flags
  always_comb begin
    out_of_range = (result.value < thresh_reg[11:0])
                 || (result.value > thresh_reg[27:16]);
    wdog_hit = result.valid && ctrl.watchdog_enable && out_of_range
             && (!(ctrl.scan_enable && ctrl.single_channel)
                 || (ctrl.channel_select <= MAX_CHANNEL
                     && result.channel == ctrl.channel_select));
    done_hit = result.valid && result.seq_last;
  end

  // ============================================================
  // AXI4-Lite slave
  assign wr_fire = aw_reg && w_reg && !b_reg;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmerge[8*i +: 8] = wstrb_reg[i] ? wdata_reg[8*i +: 8]
                                      : ctrl_reg[8*i +: 8];
    end
  end
  always_comb begin
    aw_next = aw_reg;
    w_next = w_reg;
    b_next = b_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    thresh_next = thresh_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    r_next = r_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_next = 1'b0;
      w_next = 1'b0;
      b_next = 1'b1;
      bresp_next = 2'b00;
      case (awaddr_reg)
        ADDR_CTRL0:    ctrl_next = wmerge & CTRL0_WMASK;
        ADDR_THRESH:   thresh_next = wdata_reg & 32'h0FFF_0FFF;
        ADDR_IRQ_MASK: mask_next = wdata_reg[1:0];
        ADDR_STATUS:   stat_next = stat_reg & ~wdata_reg[1:0];
        default:       bresp_next = 2'b10;
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) begin
      b_next = 1'b0;
    end
    // Hardware set wins over a same-cycle software clear.
    if (wdog_hit) begin
      stat_next[STAT_WDOG_BIT] = 1'b1;
    end
    if (done_hit) begin
      stat_next[STAT_DONE_BIT] = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_next = 1'b1;
      rresp_next = 2'b00;
      case (s_axi_araddr)
        ADDR_CTRL0:    rdata_next = ctrl_reg;
        ADDR_THRESH:   rdata_next = thresh_reg;
        ADDR_IRQ_MASK: rdata_next = {30'h0, mask_reg};
        ADDR_STATUS:   rdata_next = {30'h0, stat_reg};
        default: begin
          rdata_next = RESET_VALUE;
          rresp_next = 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      r_next = 1'b0;
    end
  end
  assign s_axi_awready = !aw_reg && !b_reg;
  assign s_axi_wready  = !w_reg && !b_reg;
  assign s_axi_bvalid  = b_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !r_reg;
  assign s_axi_rvalid  = r_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ============================================================
  // Interrupt: both the control enables and the mask must allow it.
  assign irq = (stat_reg[STAT_DONE_BIT] && ctrl.done_irq_enable
                && mask_reg[STAT_DONE_BIT])
            || (stat_reg[STAT_WDOG_BIT] && ctrl.wdog_irq_enable
                && mask_reg[STAT_WDOG_BIT]);

  // ============================================================
  // Sync start sequencing
  always_comb begin
    seq_next = seq_reg;
    cnt_next = cnt_reg;
    pri_next = 1'b0;
    sec_next = 1'b0;
    case (seq_reg)
      ST_IDLE: begin
        if (trigger) begin
          case (sync_mode)
            SYNC_FU_FAST: begin
              sec_next = 1'b1;
              cnt_next = FAST_DELAY - 5'h1;
              seq_next = ST_WAIT_PRI;
            end
            SYNC_FU_SLOW: begin
              sec_next = 1'b1;
              cnt_next = SLOW_DELAY - 5'h1;
              seq_next = ST_WAIT_PRI;
            end
            SYNC_PARALLEL: begin
              sec_next = 1'b1;
              pri_next = 1'b1;
            end
            default: pri_next = 1'b1;
          endcase
        end
      end
      ST_WAIT_PRI: begin
        if (cnt_reg != 5'h0) begin
          cnt_next = cnt_reg - 5'h1;
        end else begin
          pri_next = 1'b1;
          if (sync_mode == SYNC_FU_SLOW) begin
            cnt_next = SLOW_DELAY - 5'h1;
            seq_next = ST_WAIT_SEC;
          end else begin
            seq_next = ST_IDLE;
          end
        end
      end
      ST_WAIT_SEC: begin
        if (cnt_reg != 5'h0) begin
          cnt_next = cnt_reg - 5'h1;
        end else begin
          sec_next = 1'b1;
          seq_next = ST_IDLE;
        end
      end
      default: seq_next = ST_IDLE;
    endcase
  end
  assign start_primary   = pri_reg;
  assign start_secondary = sec_reg;

  // ============================================================
  // State registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg   <= RESET_VALUE;
      thresh_reg <= THRESH_RESET;
      stat_reg   <= 2'h0;
      mask_reg   <= 2'h0;
      aw_reg     <= 1'b0;
      w_reg      <= 1'b0;
      b_reg      <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
      bresp_reg  <= 2'b00;
      r_reg      <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= 2'b00;
      seq_reg    <= ST_IDLE;
      cnt_reg    <= 5'h00;
      pri_reg    <= 1'b0;
      sec_reg    <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      thresh_reg <= thresh_next;
      stat_reg   <= stat_next;
      mask_reg   <= mask_next;
      aw_reg     <= aw_next;
      w_reg      <= w_next;
      b_reg      <= b_next;
      awaddr_reg <= awaddr_next;
      wdata_reg  <= wdata_next;
      wstrb_reg  <= wstrb_next;
      bresp_reg  <= bresp_next;
      r_reg      <= r_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
      seq_reg    <= seq_next;
      cnt_reg    <= cnt_next;
      pri_reg    <= pri_next;
      sec_reg    <= sec_next;
    end
  end
endmodule : adcsw_ctrl

// ### bench/adcsw_ctrl_properties.sv
// Purpose: Port assertions for the converter control block.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to every adcsw_ctrl instance.
`timescale 1ns/1ps
module adcsw_ctrl_properties
  import adcsw_pkg::*;
#(
  parameter bit IS_PRIMARY = 1'b1
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Bus answers
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Engine side
  input wire adcsw_ctrl_t ctrl,
  input wire logic [3:0]  burst_length,
  input wire logic        start_primary,
  input wire logic        start_secondary,
  input wire logic        irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ==========
  // Start sequences
  sequence s_fast;
    ##7 start_primary;
  endsequence
  sequence s_slow;
    ##14 start_primary ##14 start_secondary;
  endsequence
  property p_fast;
    start_secondary && ctrl.sync_select == SYNC_FU_FAST |-> s_fast;
  endproperty
  property p_slow;
    start_secondary && ctrl.sync_select == SYNC_FU_SLOW
      && !$past(start_primary, 14) |-> s_slow;
  endproperty
  property p_par;
    IS_PRIMARY && start_primary && ctrl.sync_select == SYNC_PARALLEL
      |-> start_secondary;
  endproperty
  // The secondary copy never fires its partner start.
  property p_sec_quiet;
    !IS_PRIMARY |-> !start_secondary;
  endproperty
  property p_free;
    start_primary && ctrl.sync_select == SYNC_FREE |-> !start_secondary;
  endproperty
  property p_burst;
    burst_length == (ctrl.burst_enable ? ctrl.burst_count + 4'h1 : 4'h0);
  endproperty
  property p_irq;
    irq |-> ctrl.wdog_irq_enable || ctrl.done_irq_enable;
  endproperty
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_reset;
    $rose(arst_n) |-> ctrl == '0 && !irq;
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast follow-up timing wrong");
  a_slow: assert property (p_slow)
    else $error("slow follow-up timing wrong");
  a_par: assert property (p_par)
    else $error("parallel start not paired");
  a_sec_quiet: assert property (p_sec_quiet)
    else $error("secondary copy obeyed its sync field");
  a_free: assert property (p_free)
    else $error("free mode started secondary");
  a_burst: assert property (p_burst)
    else $error("burst length wrong");
  a_irq: assert property (p_irq)
    else $error("interrupt without enable");
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  a_rhold: assert property (p_rhold)
    else $error("read response dropped");
  a_reset: assert property (p_reset)
    else $error("control not clear after reset");
endmodule : adcsw_ctrl_properties

bind adcsw_ctrl adcsw_ctrl_properties #(.IS_PRIMARY(IS_PRIMARY)) u_props (
  .clk(clk), .arst_n(arst_n), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .ctrl(ctrl),
  .burst_length(burst_length), .start_primary(start_primary),
  .start_secondary(start_secondary), .irq(irq)
);

// ### bench/test_adcsw_ctrl.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: 25 MHz clock, register access over AXI4-Lite.
// Notes:   Sync modes, interrupts and register map are exercised.
`timescale 1ns/1ps
module test_adcsw_ctrl
  import adcsw_pkg::*;
;
  logic          clk = 1'h0, arst_n = 1'h0, trigger = 1'h0;
  logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]   wdata = 32'h0, rdata, rd_data;
  logic          awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic          arvalid = 1'h0, rready = 1'h0;
  logic          awready, wready, bvalid, arready, rvalid, sp, ss, irq;
  logic          sp2, ss2;
  logic [3:0]    wstrb = 4'hF;
  logic [1:0]    bresp, rresp, rd_resp, wr_resp;
  logic [3:0]    blen;
  adcsw_ctrl_t   ctrl;
  adcsw_result_t result = '0;
  int            miscompares = 0, comparisons = 0;
  localparam logic [3:0] MODES[4] = '{SYNC_FREE, SYNC_PARALLEL,
                                      SYNC_FU_FAST, SYNC_FU_SLOW};
  localparam int EP[4] = '{1, 1, 8, 15};
  localparam int ES1[4] = '{0, 1, 1, 1};
  localparam int ES2[4] = '{0, 0, 0, 29};
  adcsw_ctrl i_adcsw_ctrl (
    .clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .result(result),
    .trigger(trigger), .ctrl(ctrl), .burst_length(blen),
    .start_primary(sp), .start_secondary(ss), .irq(irq)
  );
  // Secondary copy: same bus traffic, its sync field must be ignored.
  adcsw_ctrl #(.IS_PRIMARY(1'b0)) i_adcsw_ctrl_sec (
    .clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready(rready), .result(result),
    .trigger(trigger), .ctrl(), .burst_length(),
    .start_primary(sp2), .start_secondary(ss2), .irq()
  );
  initial begin
    forever #20 clk = ~clk;
  end
  // ==========
  // Tasks
  task automatic chk(input string n, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) bready <= !bready;
    end while (!(bvalid && bready));
    wr_resp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) rready <= !rready;
    end while (!(rvalid && rready));
    rd_data = rdata;
    rd_resp = rresp;
  endtask : rd
  task automatic conv(input logic [4:0] ch, input logic [11:0] v,
                      input logic last);
    result <= '{1'h1, ch, v, last};
    @(posedge clk);
    result.valid <= 1'h0;
    @(posedge clk);
  endtask : conv
  task automatic seq_run(input int m);
    int p = 0, s1 = 0, s2 = 0, p2 = 0, n2 = 0;
    wr(ADDR_CTRL0, 32'h0);
    wr(ADDR_CTRL0, {12'h000, MODES[m], 16'h0000});
    trigger <= 1'h1;
    @(posedge clk);
    trigger <= 1'h0;
    for (int k = 1; k < 40; k++) begin
      #1;
      if (sp && p == 0) p = k;
      if (ss && s1 != 0) s2 = k;
      if (ss && s1 == 0) s1 = k;
      if (sp2 && p2 == 0) p2 = k;
      if (ss2) n2++;
      @(posedge clk);
    end
    chk("primary_sec", 32'(p2), 32'h1);
    chk("secondary_sec", 32'(n2), 32'h0);
    chk("primary", 32'(p), 32'(EP[m]));
    chk("secondary", 32'(s1), 32'(ES1[m]));
    chk("secondary2", 32'(s2), 32'(ES2[m]));
  endtask : seq_run
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // ==========
  // Tests
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    rd(ADDR_CTRL0);
    chk("ctrl0", rd_data, RESET_VALUE);
    rd(8'h20);
    chk("resp", {30'h0, rd_resp}, 32'h2);
    wr(8'h20, 32'h0);
    chk("bresp", {30'h0, wr_resp}, 32'h2);
    wr(ADDR_CTRL0, 32'hFFFF_FFFF);
    chk("bresp", {30'h0, wr_resp}, 32'h0);
    rd(ADDR_CTRL0);
    chk("ctrl0", rd_data, 32'h008F_EB7F);
    chk("ctrl", 32'(ctrl), 32'h0003_FFFF);
    chk("blen", 32'(blen), 32'h8);
    wstrb <= 4'h1;
    wr(ADDR_CTRL0, 32'h0);
    wstrb <= 4'hF;
    rd(ADDR_CTRL0);
    chk("ctrl0", rd_data, 32'h008F_EB00);
    wr(ADDR_CTRL0, 32'h0000_0800);
    chk("blen", 32'(blen), 32'h1);
    wr(ADDR_CTRL0, 32'h0000_E000);
    chk("blen", 32'(blen), 32'h0);
    $display("test registers done");
    for (int m = 0; m < 4; m++) seq_run(m);
    $display("test sync done");
    wr(ADDR_CTRL0, 32'h0000_0020);
    wr(ADDR_IRQ_MASK, 32'h3);
    wr(ADDR_THRESH, 32'h0800_0100);
    conv(5'h00, 12'h400, 1'h1);
    chk("irq", 32'(irq), 32'h1);
    wr(ADDR_IRQ_MASK, 32'h1);
    chk("irq", 32'(irq), 32'h0);
    wr(ADDR_IRQ_MASK, 32'h3);
    wr(ADDR_STATUS, 32'h2);
    chk("irq", 32'(irq), 32'h0);
    wr(ADDR_CTRL0, 32'h0);
    conv(5'h00, 12'h400, 1'h1);
    rd(ADDR_STATUS);
    chk("status", rd_data, 32'h2);
    chk("irq", 32'(irq), 32'h0);
    wr(ADDR_STATUS, 32'h3);
    conv(5'h00, 12'h900, 1'h0);
    rd(ADDR_STATUS);
    chk("status", rd_data, 32'h0);
    wr(ADDR_CTRL0, 32'h0080_0040);
    conv(5'h00, 12'h900, 1'h0);
    chk("irq", 32'(irq), 32'h1);
    wr(ADDR_STATUS, 32'h1);
    wr(ADDR_CTRL0, 32'h0080_0345);
    conv(5'h03, 12'h900, 1'h0);
    conv(5'h05, 12'h500, 1'h0);
    rd(ADDR_STATUS);
    chk("status", rd_data, 32'h0);
    conv(5'h05, 12'h0FF, 1'h0);
    rd(ADDR_STATUS);
    chk("status", rd_data, 32'h1);
    wr(ADDR_STATUS, 32'h1);
    wr(ADDR_CTRL0, 32'h0080_0312);
    conv(5'h12, 12'h900, 1'h0);
    rd(ADDR_STATUS);
    chk("status", rd_data, 32'h0);
    wr(ADDR_CTRL0, 32'h0080_0240);
    conv(5'h03, 12'h900, 1'h0);
    chk("irq", 32'(irq), 32'h1);
    rd(ADDR_STATUS);
    chk("status", rd_data, 32'h1);
    $display("test interrupts done");
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    chk("irq", 32'(irq), 32'h0);
    rd(ADDR_CTRL0);
    chk("ctrl0", rd_data, RESET_VALUE);
    rd(ADDR_STATUS);
    chk("status", rd_data, 32'h0);
    $display("test reset done");
    report_and_stop();
  end
endmodule : test_adcsw_ctrl
